/* rtl/hdsel_pkg.sv */
package hdsel_pkg;
    // ----------------------------------------
    // Register map (printed offsets, not multiples of four: word index)
    // ----------------------------------------
    localparam logic [7:0] RX_SUPP_A_IDX = 8'h91;
    localparam logic [7:0] TX_CTRL_A_IDX = 8'h92;
    localparam logic [7:0] TX_SUPP_A_IDX = 8'h93;
    localparam logic [7:0] RX_SUPP_B_IDX = 8'h95;
    localparam logic [7:0] TX_CTRL_B_IDX = 8'h96;
    localparam logic [7:0] TX_SUPP_B_IDX = 8'h97;
    localparam int ADDR_W = 10;
    localparam int REG_W = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hBF;
    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_MODE_BIT = 5;
    localparam int CHAN_HI = 4;
    localparam int CHAN_W = 5;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* rtl/hdsel_framer_cfg.sv */
`timescale 1ns/100ps
module hdsel_framer_cfg (
    input wire logic [7:0] rx_suppress,
    input wire logic [7:0] tx_ctrl,
    input wire logic [7:0] tx_suppress,
    input wire logic [4:0] rx_timeslot,
    input wire logic [4:0] rx_sel_chan,
    input wire logic rx_sel_enable,
    input wire logic [2:0] rx_bit_index,
    input wire logic [4:0] tx_timeslot,
    input wire logic [2:0] tx_bit_index,
    input wire logic tx_channel_block_signal,
    output logic rx_hdlc_bit_valid,
    output logic tx_hdlc_bit_use,
    output logic tx_fdl_select
);
    wire logic tx_hdlc_timeslot_enable;
    wire logic tx_timeslot_select_mode;
    wire logic [4:0] tx_chan;
    wire logic tx_slot_hit;
    wire logic rx_slot_hit;
    wire logic rx_bit_kept;
    wire logic tx_bit_kept;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    assign tx_hdlc_timeslot_enable = tx_ctrl[hdsel_pkg::CTRL_EN_BIT];
    assign tx_timeslot_select_mode = tx_ctrl[hdsel_pkg::CTRL_MODE_BIT];
    assign tx_chan = tx_ctrl[hdsel_pkg::CHAN_HI:0]; // [RQ4]

    // ----------------------------------------
    // Timeslot selection
    // ----------------------------------------
    assign tx_slot_hit = tx_timeslot_select_mode ? tx_channel_block_signal
                                                 : (tx_timeslot == tx_chan); // [RQ3]
    assign rx_slot_hit = rx_sel_enable && (rx_timeslot == rx_sel_chan);

    // Bit index 0 is the MSB of the timeslot
    assign rx_bit_kept = !rx_suppress[3'h7 - rx_bit_index]; // [RQ1]
    assign tx_bit_kept = !tx_suppress[3'h7 - tx_bit_index]; // [RQ2]

    assign rx_hdlc_bit_valid = rx_slot_hit && rx_bit_kept; // [RQ1]
    assign tx_hdlc_bit_use = tx_hdlc_timeslot_enable && tx_slot_hit && tx_bit_kept; // [RQ2] [RQ5]
    assign tx_fdl_select = !tx_hdlc_timeslot_enable; // [RQ5]
endmodule

/* rtl/hdsel_regs.sv */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// How it works
// (RQ1) Receive suppress bit set drops that DS0 bit; bit 7 is MSB.
// (RQ2) Transmit suppress bit set keeps that DS0 bit from HDLC data.
// (RQ3) Mode 0 uses channel number; mode 1 uses channel-block signal.
// (RQ4) Low five control bits form binary DS0 channel number.
// (RQ5) Enable 0 sends HDLC to data link; 1 inserts it into timeslots.
module hdsel_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [4:0] rx_timeslot_a,
    input wire logic [4:0] rx_sel_chan_a,
    input wire logic rx_sel_enable_a,
    input wire logic [2:0] rx_bit_index_a,
    input wire logic [4:0] tx_timeslot_a,
    input wire logic [2:0] tx_bit_index_a,
    input wire logic tx_channel_block_signal_a,
    output logic rx_hdlc_bit_valid_a,
    output logic tx_hdlc_bit_use_a,
    output logic tx_fdl_select_a,
    input wire logic [4:0] rx_timeslot_b,
    input wire logic [4:0] rx_sel_chan_b,
    input wire logic rx_sel_enable_b,
    input wire logic [2:0] rx_bit_index_b,
    input wire logic [4:0] tx_timeslot_b,
    input wire logic [2:0] tx_bit_index_b,
    input wire logic tx_channel_block_signal_b,
    output logic rx_hdlc_bit_valid_b,
    output logic tx_hdlc_bit_use_b,
    output logic tx_fdl_select_b
);
    logic [7:0] rx_supp_a_reg;
    logic [7:0] tx_ctrl_a_reg;
    logic [7:0] tx_supp_a_reg;
    logic [7:0] rx_supp_b_reg;
    logic [7:0] tx_ctrl_b_reg;
    logic [7:0] tx_supp_b_reg;
    logic [31:0] rdata_reg;
    logic done_reg;
    wire logic [7:0] idx;
    wire logic hi_zero;
    wire logic wr_lane;
    wire logic wr_go;
    wire logic [7:0] wdata;
    wire logic [7:0] wctrl;
    logic [7:0] rd_mux;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Word index is address bits [9:2]; one-wait-state answer
    assign idx = avs_address[9:2];
    assign hi_zero = (avs_address[1:0] == 2'h0);
    assign wr_lane = avs_byteenable[0];
    assign wdata = avs_writedata[7:0];
    assign wctrl = avs_writedata[7:0] & hdsel_pkg::CTRL_WMASK;
    assign wr_go = avs_write && done_reg && wr_lane && hi_zero;
    assign avs_waitrequest = (avs_read || avs_write) && !done_reg;
    assign avs_readdata = rdata_reg;

    always_comb begin
        rd_mux = hdsel_pkg::REG_RESET;
        unique case (idx)
            hdsel_pkg::RX_SUPP_A_IDX: rd_mux = rx_supp_a_reg;
            hdsel_pkg::TX_CTRL_A_IDX: rd_mux = tx_ctrl_a_reg;
            hdsel_pkg::TX_SUPP_A_IDX: rd_mux = tx_supp_a_reg;
            hdsel_pkg::RX_SUPP_B_IDX: rd_mux = rx_supp_b_reg;
            hdsel_pkg::TX_CTRL_B_IDX: rd_mux = tx_ctrl_b_reg;
            hdsel_pkg::TX_SUPP_B_IDX: rd_mux = tx_supp_b_reg;
            default: rd_mux = hdsel_pkg::REG_RESET;
        endcase
    end

    // ----------------------------------------
    // Handshake and read data
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
            rdata_reg <= hdsel_pkg::UNMAPPED_DATA;
        end else begin
            done_reg <= (avs_read || avs_write) && !done_reg;
            if (avs_read && !done_reg) begin
                rdata_reg <= {24'h000000, rd_mux};
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_supp_a_reg <= hdsel_pkg::REG_RESET;
            tx_ctrl_a_reg <= hdsel_pkg::REG_RESET;
            tx_supp_a_reg <= hdsel_pkg::REG_RESET;
            rx_supp_b_reg <= hdsel_pkg::REG_RESET;
            tx_ctrl_b_reg <= hdsel_pkg::REG_RESET;
            tx_supp_b_reg <= hdsel_pkg::REG_RESET;
        end else if (wr_go) begin
            if (idx == hdsel_pkg::RX_SUPP_A_IDX) rx_supp_a_reg <= wdata; // [RQ1]
            if (idx == hdsel_pkg::TX_CTRL_A_IDX) tx_ctrl_a_reg <= wctrl; // [RQ3]
            if (idx == hdsel_pkg::TX_SUPP_A_IDX) tx_supp_a_reg <= wdata; // [RQ2]
            if (idx == hdsel_pkg::RX_SUPP_B_IDX) rx_supp_b_reg <= wdata; // [RQ1]
            if (idx == hdsel_pkg::TX_CTRL_B_IDX) tx_ctrl_b_reg <= wctrl; // [RQ3]
            if (idx == hdsel_pkg::TX_SUPP_B_IDX) tx_supp_b_reg <= wdata; // [RQ2]
        end
    end

    // ----------------------------------------
    // Per-framer selection
    // ----------------------------------------
    hdsel_framer_cfg u_framer_a (
        .rx_suppress(rx_supp_a_reg),
        .tx_ctrl(tx_ctrl_a_reg),
        .tx_suppress(tx_supp_a_reg),
        .rx_timeslot(rx_timeslot_a),
        .rx_sel_chan(rx_sel_chan_a),
        .rx_sel_enable(rx_sel_enable_a),
        .rx_bit_index(rx_bit_index_a),
        .tx_timeslot(tx_timeslot_a),
        .tx_bit_index(tx_bit_index_a),
        .tx_channel_block_signal(tx_channel_block_signal_a),
        .rx_hdlc_bit_valid(rx_hdlc_bit_valid_a),
        .tx_hdlc_bit_use(tx_hdlc_bit_use_a),
        .tx_fdl_select(tx_fdl_select_a)
    );

    hdsel_framer_cfg u_framer_b (
        .rx_suppress(rx_supp_b_reg),
        .tx_ctrl(tx_ctrl_b_reg),
        .tx_suppress(tx_supp_b_reg),
        .rx_timeslot(rx_timeslot_b),
        .rx_sel_chan(rx_sel_chan_b),
        .rx_sel_enable(rx_sel_enable_b),
        .rx_bit_index(rx_bit_index_b),
        .tx_timeslot(tx_timeslot_b),
        .tx_bit_index(tx_bit_index_b),
        .tx_channel_block_signal(tx_channel_block_signal_b),
        .rx_hdlc_bit_valid(rx_hdlc_bit_valid_b),
        .tx_hdlc_bit_use(tx_hdlc_bit_use_b),
        .tx_fdl_select(tx_fdl_select_b)
    );
endmodule

/* tb/hdsel_regs_monitor.sv */
`timescale 1ns/100ps
module hdsel_regs_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [4:0] rx_timeslot_a,
    input wire logic [4:0] rx_sel_chan_a,
    input wire logic rx_hdlc_bit_valid_a,
    input wire logic tx_hdlc_bit_use_a,
    input wire logic tx_fdl_select_a,
    input wire logic tx_hdlc_bit_use_b,
    input wire logic tx_fdl_select_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_wait_first; $rose(avs_write) || $rose(avs_read) |-> avs_waitrequest; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_wait_once; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_once: assert property (p_wait_once) else $error("wait too long");
    property p_rdata_hold; !avs_read |=> $stable(avs_readdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_excl_a; tx_hdlc_bit_use_a |-> !tx_fdl_select_a; endproperty
    a_excl_a: assert property (p_excl_a) else $error("slot use in link mode a");
    property p_excl_b; tx_hdlc_bit_use_b |-> !tx_fdl_select_b; endproperty
    a_excl_b: assert property (p_excl_b) else $error("slot use in link mode b");
    property p_fdl_hold_a; !avs_write |=> $stable(tx_fdl_select_a); endproperty
    a_fdl_hold_a: assert property (p_fdl_hold_a) else $error("link select a moved");
    property p_fdl_hold_b; !avs_write |=> $stable(tx_fdl_select_b); endproperty
    a_fdl_hold_b: assert property (p_fdl_hold_b) else $error("link select b moved");
    property p_rx_hit_a; rx_hdlc_bit_valid_a |-> rx_timeslot_a == rx_sel_chan_a; endproperty
    a_rx_hit_a: assert property (p_rx_hit_a) else $error("rx bit off slot");
endmodule
bind hdsel_regs hdsel_regs_monitor i_mon (.mclk, .rst, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .rx_timeslot_a, .rx_sel_chan_a, .rx_hdlc_bit_valid_a,
    .tx_hdlc_bit_use_a, .tx_fdl_select_a, .tx_hdlc_bit_use_b, .tx_fdl_select_b);

/* tb/hdsel_framer_model.sv */
`timescale 1ns/100ps
module hdsel_framer_model (
    input wire logic mclk,
    input wire logic rst,
    output logic [4:0] slot,
    output logic [2:0] bit_idx,
    output logic chblk
);
    // ----------------------------------------
    // Timeslot counter, 24 slots of 8 bits
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slot <= 5'h00;
            bit_idx <= 3'h0;
        end else begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7)
                slot <= (slot == 5'h17) ? 5'h00 : slot + 5'h01;
        end
    end
    assign chblk = slot[0];
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
    logic mclk, rst, rd, wr, wreq, ena, enb, va, ua, fa, vb, ub, fb, ka, kb;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] be;
    logic [4:0] sela, selb, sa, sb;
    logic [2:0] ia, ib;
    logic [7:0] sh [6] = '{default: 8'h00};
    int error_cnt = 0, n_checks = 0;
    hdsel_framer_model i_fa (.mclk, .rst, .slot(sa), .bit_idx(ia), .chblk(ka));
    hdsel_framer_model i_fb (.mclk, .rst, .slot(sb), .bit_idx(ib), .chblk(kb));
    hdsel_regs i_dut (.mclk, .rst, .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .rx_timeslot_a(sa), .rx_sel_chan_a(sela), .rx_sel_enable_a(ena), .rx_bit_index_a(ia),
        .tx_timeslot_a(sa), .tx_bit_index_a(ia), .tx_channel_block_signal_a(ka),
        .rx_hdlc_bit_valid_a(va), .tx_hdlc_bit_use_a(ua), .tx_fdl_select_a(fa),
        .rx_timeslot_b(sb), .rx_sel_chan_b(selb), .rx_sel_enable_b(enb), .rx_bit_index_b(ib),
        .tx_timeslot_b(sb), .tx_bit_index_b(ib), .tx_channel_block_signal_b(kb),
        .rx_hdlc_bit_valid_b(vb), .tx_hdlc_bit_use_b(ub), .tx_fdl_select_b(fb));
    // ----------------------------------------
    // Bus access and expected outputs
    // ----------------------------------------
    function automatic logic [9:0] ad(input int i);
        return {8'h91 + 8'(i) + 8'(i > 2), 2'b00};
    endfunction
    function automatic logic [2:0] ex(input logic [7:0] rs, c, ts, input logic [4:0] s, sel,
        input logic [2:0] b, input logic en, k);
        ex[2] = en && s == sel && !rs[3'h7 - b];
        ex[1] = c[7] && (c[5] ? k : s == c[4:0]) && !ts[3'h7 - b];
        ex[0] = !c[7];
    endfunction
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, input logic b0);
        @(posedge mclk);
        wr <= w; rd <= !w; addr <= a; wdata <= {24'h0, d}; be <= {3'h0, b0};
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        rdat = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wreg(input int i, input logic [7:0] d);
        acc(1'b1, ad(i), d, 1'b1);
        sh[i] = (i % 3 == 1) ? d & hdsel_pkg::CTRL_WMASK : d;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(negedge mclk) begin
        if (!rst) begin
            `CHK("frm_a", ex(sh[0], sh[1], sh[2], sa, sela, ia, ena, ka), {va, ua, fa})
            `CHK("frm_b", ex(sh[3], sh[4], sh[5], sb, selb, ib, enb, kb), {vb, ub, fb})
        end
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (6000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 10'h000; wdata = 32'h0; be = 4'hF;
        ena = 1'b1; enb = 1'b1; sela = 5'h05; selb = 5'h17;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ad(i), 8'h00, 1'b1);
            `CHK("reset", 32'h0, rdat)
        end
        wreg(0, 8'h01); wreg(1, 8'hC5); wreg(2, 8'h81);
        wreg(3, 8'hFE); wreg(4, 8'hA0); wreg(5, 8'h3C);
        acc(1'b1, ad(1), 8'hFF, 1'b0);
        acc(1'b1, ad(2) | 10'h001, 8'hFF, 1'b1);
        acc(1'b1, 10'h250, 8'hFF, 1'b1);
        acc(1'b0, 10'h250, 8'h00, 1'b1);
        `CHK("unmapped", 32'h0, rdat)
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ad(i), 8'h00, 1'b1);
            `CHK("readback", {24'h0, sh[i]}, rdat)
        end
        repeat (400) @(posedge mclk);
        wreg(1, 8'h17); wreg(4, 8'h97); wreg(3, 8'h80); wreg(5, 8'h00);
        enb <= 1'b0;
        repeat (400) @(posedge mclk);
        print_verdict();
    end
endmodule
